// ==== rtl/wsa_params.svh ====
`ifndef WSA_PARAMS_SVH
`define WSA_PARAMS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define WSA_OFS_CTRL 8'h00
`define WSA_OFS_REPEAT 8'h04
`define WSA_OFS_LAST_ROW 8'h08
`define WSA_OFS_TBL_ADDR 8'h0c
`define WSA_OFS_TBL_ROW 8'h10
`define WSA_OFS_TBL_LOOPS 8'h14
`define WSA_OFS_SEG_ADDR 8'h18
`define WSA_OFS_SEG_START 8'h1c
`define WSA_OFS_SEG_LEN 8'h20
`define WSA_OFS_SW_ADV 8'h24
`define WSA_OFS_STATUS 8'h28

// ----------------------------------------
// field positions
// ----------------------------------------
`define WSA_CTRL_RUN 0
`define WSA_CTRL_ARMED 1
`define WSA_CTRL_MODE_LSB 2
`define WSA_CTRL_SRC_LSB 4
`define WSA_ROW_LINK_LSB 8
`define WSA_ROW_JUMP 16
`define WSA_STAT_PEND 8
`define WSA_STAT_STALL 9
`define WSA_STAT_UNDER 10
`define WSA_STAT_STATE_LSB 12

// ----------------------------------------
// default sizes
// ----------------------------------------
`define WSA_ROW_AW 8
`define WSA_SEG_AW 8
`define WSA_ADDR_W 24
`define WSA_LOOP_W 20

`endif

// ==== rtl/wsa_pkg.sv ====
package wsa_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARM = 4'b0010,
        ST_LOAD = 4'b0100,
        ST_PLAY = 4'b1000
    } state_type;

    typedef enum logic [1:0] {
        MODE_AUTO = 2'h0,
        MODE_ONCE = 2'h1,
        MODE_STEP = 2'h2
    } mode_type;

    typedef enum logic [1:0] {
        SRC_BUTTON = 2'h0,
        SRC_TRIG = 2'h1,
        SRC_EVENT = 2'h2,
        SRC_SW = 2'h3
    } src_type;

endpackage

// ==== rtl/seq_mem.sv ====
`timescale 1ns/1ps
module seq_mem #(
    parameter int DW = 32,
    parameter int AW = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // read port, one cycle latency
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule

// ==== rtl/waveform_sequence_advance.sv ====
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "wsa_params.svh"
module waveform_sequence_advance #(
    parameter int ROW_AW = `WSA_ROW_AW,
    parameter int SEG_AW = `WSA_SEG_AW,
    parameter int ADDR_W = `WSA_ADDR_W,
    parameter int LOOP_W = `WSA_LOOP_W
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // advance stimulus pins
    input wire logic MANUAL_TRIGGER_BUTTON,
    input wire logic TRIG_IN,
    input wire logic EVENT_IN,
    // sample path toward the waveform memory and dac
    output logic [ADDR_W-1:0] SAMPLE_ADDR,
    output logic SAMPLE_VALID,
    output logic [SEG_AW-1:0] SEG_NUM,
    output logic [ROW_AW-1:0] STEP_LINK
);
    import wsa_pkg::*;

    // ----------------------------------------
    // table layouts
    // ----------------------------------------
    localparam int RW = 1 + ROW_AW + SEG_AW + LOOP_W;
    localparam int SW = 2 * ADDR_W;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic run;
        logic armed;
        mode_type mode;
        src_type src;
        logic [LOOP_W-1:0] repeat_cnt;
        logic [ROW_AW-1:0] last_row;
        logic [ROW_AW-1:0] tbl_addr;
        logic [SEG_AW-1:0] tbl_seg;
        logic [ROW_AW-1:0] tbl_link;
        logic tbl_jump;
        logic [SEG_AW-1:0] seg_addr;
        logic [ADDR_W-1:0] seg_start;
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic pend;
        logic under;
        state_type st;
        logic [1:0] pf_ph;
        logic [ROW_AW-1:0] pf_row;
        logic nxt_v;
        logic [ADDR_W-1:0] n_start;
        logic [ADDR_W-1:0] n_len;
        logic [LOOP_W-1:0] n_loops;
        logic n_jump;
        logic [ROW_AW-1:0] n_link;
        logic [SEG_AW-1:0] n_seg;
        logic [ROW_AW-1:0] row;
        logic [ADDR_W-1:0] start;
        logic [ADDR_W-1:0] len;
        logic [ADDR_W-1:0] off;
        logic [LOOP_W-1:0] loops;
        logic jump;
        logic [ROW_AW-1:0] link;
        logic [SEG_AW-1:0] seg;
        logic [LOOP_W-1:0] rep_left;
        logic stall;
        logic out_v;
        logic [ADDR_W-1:0] out_addr;
    } st_type;

    st_type q;
    st_type d;

    logic row_we;
    logic [RW-1:0] row_wdata;
    logic [RW-1:0] row_rdata;
    logic seg_we;
    logic [SW-1:0] seg_wdata;
    logic [SW-1:0] seg_rdata;
    logic [SEG_AW-1:0] rd_seg;
    logic [2:0] rise;
    logic evt;
    logic req;
    logic wr;
    logic at_end;
    logic hold;
    logic uses_evt;
    logic [31:0] rd;

    // ----------------------------------------
    // byte-lane merge for the ctrl and repeat registers
    // ----------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ----------------------------------------
    // sequence table and segment descriptors
    // ----------------------------------------
    // row: jump, link, segment, loops
    assign row_wdata = {q.tbl_jump, q.tbl_link, q.tbl_seg, WB_DAT_I[LOOP_W-1:0]};
    assign rd_seg = row_rdata[LOOP_W +: SEG_AW];
    assign seg_wdata = {q.seg_start, WB_DAT_I[ADDR_W-1:0]};

    seq_mem #(.DW(RW), .AW(ROW_AW)) u_rows (
        .clk(CLK),
        .resetn(RESETN),
        .we(row_we),
        .waddr(q.tbl_addr),
        .wdata(row_wdata),
        .raddr(q.pf_row),
        .rdata(row_rdata)
    );

    // the read address follows the row output directly so a lookup takes two reads
    seq_mem #(.DW(SW), .AW(SEG_AW)) u_segs (
        .clk(CLK),
        .resetn(RESETN),
        .we(seg_we),
        .waddr(q.seg_addr),
        .wdata(seg_wdata),
        .raddr(rd_seg),
        .rdata(seg_rdata)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d = q;
        req = WB_CYC_I && WB_STB_I;
        wr = req && WB_WE_I && q.ack;
        row_we = wr && (WB_ADR_I == `WSA_OFS_TBL_LOOPS);
        seg_we = wr && (WB_ADR_I == `WSA_OFS_SEG_LEN);
        // s1 is seen only by s2; edges come from the settled copies
        d.s1 = {MANUAL_TRIGGER_BUTTON, TRIG_IN, EVENT_IN};
        d.s2 = q.s1;
        d.s3 = q.s2;
        rise = q.s2 & ~q.s3;
        case (q.src)
            SRC_BUTTON: evt = rise[2];
            SRC_TRIG: evt = rise[1];
            SRC_EVENT: evt = rise[0];
            SRC_SW: evt = wr && (WB_ADR_I == `WSA_OFS_SW_ADV);
            default: evt = 1'b0;
        endcase
        at_end = (q.off == q.len - ADDR_W'(1));
        uses_evt = (q.mode == MODE_STEP) || q.jump;
        hold = (q.mode == MODE_STEP) ? !q.pend : (q.jump && !q.pend);

        // bus slave: ack one cycle after the request, dropped the cycle after
        d.ack = req && !q.ack;
        rd = '0;
        case (WB_ADR_I)
            `WSA_OFS_CTRL: begin
                rd[`WSA_CTRL_RUN] = q.run;
                rd[`WSA_CTRL_ARMED] = q.armed;
                rd[`WSA_CTRL_MODE_LSB +: 2] = q.mode;
                rd[`WSA_CTRL_SRC_LSB +: 2] = q.src;
            end
            `WSA_OFS_REPEAT: rd[LOOP_W-1:0] = q.repeat_cnt;
            `WSA_OFS_LAST_ROW: rd[ROW_AW-1:0] = q.last_row;
            `WSA_OFS_TBL_ADDR: rd[ROW_AW-1:0] = q.tbl_addr;
            `WSA_OFS_SEG_ADDR: rd[SEG_AW-1:0] = q.seg_addr;
            `WSA_OFS_STATUS: begin
                rd[ROW_AW-1:0] = q.row;
                rd[`WSA_STAT_PEND] = q.pend;
                rd[`WSA_STAT_STALL] = q.stall;
                rd[`WSA_STAT_UNDER] = q.under;
                rd[`WSA_STAT_STATE_LSB +: 4] = q.st;
            end
            default: rd = '0;
        endcase
        if (req && !q.ack) begin
            d.dat = rd;
        end
        if (wr) begin
            case (WB_ADR_I)
                `WSA_OFS_CTRL: begin
                    rd = merge({26'h0, q.src, q.mode, q.armed, q.run}, WB_DAT_I, WB_SEL_I);
                    d.run = rd[`WSA_CTRL_RUN];
                    d.armed = rd[`WSA_CTRL_ARMED];
                    // the fourth mode code is not a mode; keep the old one
                    if (rd[`WSA_CTRL_MODE_LSB +: 2] != 2'h3) begin
                        d.mode = mode_type'(rd[`WSA_CTRL_MODE_LSB +: 2]);
                    end
                    d.src = src_type'(rd[`WSA_CTRL_SRC_LSB +: 2]);
                end
                `WSA_OFS_REPEAT: begin
                    rd = merge(32'(q.repeat_cnt), WB_DAT_I, WB_SEL_I);
                    d.repeat_cnt = rd[LOOP_W-1:0];
                end
                `WSA_OFS_LAST_ROW: d.last_row = WB_DAT_I[ROW_AW-1:0];
                `WSA_OFS_TBL_ADDR: d.tbl_addr = WB_DAT_I[ROW_AW-1:0];
                `WSA_OFS_TBL_ROW: begin
                    d.tbl_seg = WB_DAT_I[SEG_AW-1:0];
                    d.tbl_link = WB_DAT_I[`WSA_ROW_LINK_LSB +: ROW_AW];
                    d.tbl_jump = WB_DAT_I[`WSA_ROW_JUMP];
                end
                `WSA_OFS_SEG_ADDR: d.seg_addr = WB_DAT_I[SEG_AW-1:0];
                `WSA_OFS_SEG_START: d.seg_start = WB_DAT_I[ADDR_W-1:0];
                `WSA_OFS_STATUS: d.under = 1'b0;
                default: d.run = q.run;
            endcase
        end

        // pending advance waits for a boundary; a new event beats the clear
        d.pend = q.pend | evt;

        // prefetch of the next row keeps the boundary free of gaps
        if (q.st != ST_IDLE && !q.nxt_v) begin
            case (q.pf_ph)
                2'h0: d.pf_ph = 2'h1;
                2'h1: begin
                    d.n_loops = row_rdata[LOOP_W-1:0];
                    d.n_seg = rd_seg;
                    d.n_link = row_rdata[LOOP_W+SEG_AW +: ROW_AW];
                    d.n_jump = row_rdata[RW-1];
                    d.pf_ph = 2'h2;
                end
                default: begin
                    d.n_start = seg_rdata[SW-1:ADDR_W];
                    d.n_len = seg_rdata[ADDR_W-1:0];
                    d.nxt_v = 1'b1;
                    d.pf_ph = 2'h0;
                end
            endcase
        end

        d.out_v = 1'b0;
        case (q.st)
            ST_IDLE: begin
                d.pend = 1'b0;
                d.stall = 1'b0;
                d.nxt_v = 1'b0;
                d.pf_ph = 2'h0;
                d.pf_row = '0;
                d.rep_left = q.repeat_cnt;
                if (q.run) begin
                    // sequencing relies on software having loaded the table first
                    if (q.mode == MODE_AUTO && !q.armed) begin
                        d.st = ST_LOAD;
                    end else begin
                        d.st = ST_ARM;
                    end
                end
            end
            ST_ARM: begin
                if (q.pend) begin
                    d.pend = evt;
                    d.rep_left = q.repeat_cnt;
                    d.st = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (q.nxt_v) begin
                    d.st = ST_PLAY;
                    d.start = q.n_start;
                    d.len = q.n_len;
                    d.loops = q.n_loops;
                    d.jump = q.n_jump;
                    d.link = q.n_link;
                    d.seg = q.n_seg;
                    d.row = q.pf_row;
                    d.off = '0;
                    d.pf_row = (q.pf_row == q.last_row) ? '0 : q.pf_row + ROW_AW'(1);
                    d.nxt_v = 1'b0;
                end
            end
            ST_PLAY: begin
                if (!q.stall) begin
                    d.out_v = 1'b1;
                    d.out_addr = q.start + q.off;
                end
                if (!q.stall && !at_end) begin
                    d.off = q.off + ADDR_W'(1);
                end else if (!q.stall && q.loops > LOOP_W'(1)) begin
                    d.loops = q.loops - LOOP_W'(1);
                    d.off = '0;
                end else if (!q.stall && hold) begin
                    d.off = '0;
                end else if (q.mode == MODE_ONCE && q.row == q.last_row
                             && q.rep_left <= LOOP_W'(1)) begin
                    // pass count used up: wait for a fresh trigger
                    d.st = ST_ARM;
                    d.stall = 1'b0;
                    d.nxt_v = 1'b0;
                    d.pf_ph = 2'h0;
                    d.pf_row = '0;
                    if (uses_evt) begin
                        d.pend = evt;
                    end
                end else if (q.nxt_v) begin
                    // last row wraps to row zero in every mode
                    if (q.mode == MODE_ONCE && q.row == q.last_row) begin
                        d.rep_left = q.rep_left - LOOP_W'(1);
                    end
                    if (uses_evt && !q.stall) begin
                        d.pend = evt;
                    end
                    d.stall = 1'b0;
                    d.start = q.n_start;
                    d.len = q.n_len;
                    d.loops = q.n_loops;
                    d.jump = q.n_jump;
                    d.link = q.n_link;
                    d.seg = q.n_seg;
                    d.row = q.pf_row;
                    d.off = '0;
                    d.pf_row = (q.pf_row == q.last_row) ? '0 : q.pf_row + ROW_AW'(1);
                    d.nxt_v = 1'b0;
                end else begin
                    // segment too short to hide the prefetch: gap, flagged
                    if (uses_evt && !q.stall) begin
                        d.pend = evt;
                    end
                    d.stall = 1'b1;
                    d.under = 1'b1;
                end
            end
            default: d.st = ST_IDLE;
        endcase

        if (!q.run) begin
            d.st = ST_IDLE;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // one instance serves exactly one channel
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.mode <= MODE_AUTO;
            q.src <= SRC_BUTTON;
        end else begin
            q <= d;
        end
    end

    assign WB_ACK_O = q.ack;
    assign WB_DAT_O = q.dat;
    assign SAMPLE_ADDR = q.out_addr;
    assign SAMPLE_VALID = q.out_v;
    assign SEG_NUM = q.seg;
    assign STEP_LINK = q.link;
endmodule

// ==== bench/wsa_checker_assertions.sv ====
`timescale 1ns/1ps
module wsa_checker #(
    parameter int ADDR_W = 24
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // wishbone
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // sample path
    input wire logic [ADDR_W-1:0] SAMPLE_ADDR,
    input wire logic SAMPLE_VALID
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    ack_follows_req_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not answered in the next cycle");
    no_stray_ack_a: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
        else $error("ack without a request");
    unmapped_zero_a: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I > 8'h28
        |-> WB_DAT_O == 32'h0) else $error("unmapped read not zero");
    state_onehot_a: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h28
        |-> $onehot(WB_DAT_O[15:12])) else $error("state field not one-hot");
    reset_quiet_a: assert property ($rose(RESETN) |-> !SAMPLE_VALID && SAMPLE_ADDR == '0)
        else $error("sample path active out of reset");
    // clearing run must silence the path before any restart could land
    run_abort_a: assert property (WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h00
        && WB_SEL_I[0] && !WB_DAT_I[0] |-> ##3 !SAMPLE_VALID [*4])
        else $error("samples continue after run cleared");
    idle_silent_a: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h28
        && WB_DAT_O[12] |=> !SAMPLE_VALID [*2]) else $error("samples while idle");
endmodule

bind waveform_sequence_advance wsa_checker #(.ADDR_W(ADDR_W)) u_chk (
    .CLK(CLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SAMPLE_ADDR(SAMPLE_ADDR),
    .SAMPLE_VALID(SAMPLE_VALID));

// ==== bench/wsa_far_side.sv ====
`timescale 1ns/1ps
module wsa_far_side #(
    parameter int ADDR_W = 24
) (
    // clock
    input wire logic clk,
    // sample path from the sequencer
    input wire logic [ADDR_W-1:0] sample_addr,
    input wire logic sample_valid,
    // advance stimulus pins
    output logic btn_pin,
    output logic trig,
    output logic evt
);
    int got[$];
    int gaps;
    initial begin
        btn_pin = 0;
        trig = 0;
        evt = 0;
        gaps = 0;
    end
    // dac side: every issued sample is kept, idle cycles after the first are counted
    always @(posedge clk) begin
        if (sample_valid)
            got.push_back(int'(sample_addr));
        else if (got.size() > 0)
            gaps++;
    end
    // three cycles high and low so the two-stage sync always sees the edge
    task pulse(input int s);
        @(posedge clk);
        btn_pin <= (s == 0);
        trig <= (s == 1);
        evt <= (s == 2);
        repeat (3) @(posedge clk);
        {btn_pin, trig, evt} <= 3'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import wsa_pkg::*;
    logic CLK, RESETN, cyc, stb, we, ack, btn, trg, evt, vld;
    logic [7:0] adr, seg, link;
    logic [31:0] dat, dout, rd;
    logic [23:0] addr;
    int miscompares, n_compared, g, r, n0, sg[3], lk[3], lp[3], ss[4], sl[4], exp_q[$];

    waveform_sequence_advance dut (.CLK(CLK), .RESETN(RESETN), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat),
        .WB_DAT_O(dout), .WB_ACK_O(ack), .MANUAL_TRIGGER_BUTTON(btn), .TRIG_IN(trg),
        .EVENT_IN(evt), .SAMPLE_ADDR(addr), .SAMPLE_VALID(vld), .SEG_NUM(seg),
        .STEP_LINK(link));
    wsa_far_side #(.ADDR_W(24)) far (.clk(CLK), .sample_addr(addr), .sample_valid(vld),
        .btn_pin(btn), .trig(trg), .evt(evt));

    initial begin
        CLK = 0;
        forever #5 CLK = ~CLK;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task results;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task stuck(input string what);
        miscompares++;
        $display("wrong value at %0t: %s timed out", $time, what);
        results();
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dout;
        cyc <= 0;
        stb <= 0;
        if (n >= 20)
            stuck("bus");
    endtask
    function logic [31:0] ctl(input mode_type m, input src_type s, input logic arm);
        return {26'h0, s, m, arm, 1'b1};
    endfunction
    task fire(input int s);
        if (s == 3)
            wb(1, 8'h24, 32'h1);
        else
            far.pulse(s);
    endtask
    task until_seg(input int s);
        int n;
        n = 0;
        while (seg !== s[7:0] && n < 400) begin
            @(posedge CLK);
            n++;
        end
        if (n >= 400)
            stuck("segment");
    endtask
    task until_n(input int k);
        int n;
        n = 0;
        while (far.got.size() < k && n < 3000) begin
            @(posedge CLK);
            n++;
        end
        if (n >= 3000)
            stuck("samples");
    endtask
    task row(input int i, input logic j);
        wb(1, 8'h0c, i);
        wb(1, 8'h10, {15'h0, j, lk[i][7:0], sg[i][7:0]});
        wb(1, 8'h14, lp[i]);
    endtask
    // reference stream: rows ascending, each segment repeated for its loop count
    task mk(input int last, input int passes);
        exp_q.delete();
        repeat (passes)
            for (int i = 0; i <= last; i++)
                for (int l = 0; l < lp[i]; l++)
                    for (int k = 0; k < sl[sg[i]]; k++)
                        exp_q.push_back(ss[sg[i]] + k);
    endtask
    task cmp(input int base);
        for (int i = 0; i < exp_q.size(); i++)
            chk(far.got[base + i], exp_q[i]);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {cyc, stb, we, adr, dat, RESETN, miscompares, n_compared} = '0;
        void'($urandom(96636));
        for (int i = 0; i < 3; i++) begin
            sg[i] = i + 1;
            lk[i] = $urandom_range(0, 255);
            lp[i] = $urandom_range(1, 3);
            ss[i + 1] = (i + 1) * 32 + $urandom_range(0, 7);
            sl[i + 1] = $urandom_range(4, 9);
        end
        repeat (10) @(posedge CLK);
        RESETN <= 1;
        wb(0, 8'h00, 0);
        chk(rd, 32'h0);
        // the fourth mode code must leave the stored mode alone
        wb(1, 8'h00, 32'h4);
        wb(1, 8'h00, 32'hc);
        wb(0, 8'h00, 0);
        chk(rd, 32'h4);
        wb(0, 8'h28, 0);
        chk(rd, 32'h1000);
        wb(1, 8'h40, 32'hffffffff);
        wb(0, 8'h40, 0);
        chk(rd, 32'h0);
        wb(1, 8'h08, 2);
        wb(0, 8'h08, 0);
        chk(rd, 32'h2);
        $display("test registers done");
        // whole table is loaded before any run
        for (int k = 1; k < 4; k++) begin
            wb(1, 8'h18, k);
            wb(1, 8'h1c, ss[k]);
            wb(1, 8'h20, sl[k]);
        end
        for (int i = 0; i < 3; i++)
            row(i, 0);
        far.got.delete();
        wb(1, 8'h00, ctl(MODE_AUTO, SRC_BUTTON, 0));
        mk(2, 2);
        until_n(exp_q.size());
        g = far.gaps;
        wb(1, 8'h00, 0);
        cmp(0);
        chk(g, 0);
        $display("test auto done");
        // a stopped run still issues its last samples; let them drain first
        repeat (4) @(posedge CLK);
        far.got.delete();
        wb(1, 8'h00, ctl(MODE_AUTO, SRC_TRIG, 1));
        repeat (30) @(posedge CLK);
        chk(far.got.size(), 0);
        fire(1);
        until_n(4);
        wb(1, 8'h00, 0);
        chk(far.got[0], ss[1]);
        $display("test armed done");
        r = $urandom_range(1, 3);
        wb(1, 8'h04, r);
        repeat (4) @(posedge CLK);
        far.got.delete();
        wb(1, 8'h00, ctl(MODE_ONCE, SRC_EVENT, 0));
        fire(2);
        mk(2, r);
        n0 = exp_q.size();
        until_n(n0);
        repeat (60) @(posedge CLK);
        chk(far.got.size(), n0);
        cmp(0);
        fire(2);
        until_n(2 * n0);
        repeat (60) @(posedge CLK);
        chk(far.got.size(), 2 * n0);
        cmp(n0);
        wb(1, 8'h00, 0);
        $display("test once done");
        wb(1, 8'h08, 1);
        wb(1, 8'h00, ctl(MODE_STEP, SRC_BUTTON, 0));
        fire(0);
        until_seg(sg[0]);
        r = 0;
        for (int s = 0; s < 4; s++) begin
            wb(1, 8'h00, ctl(MODE_STEP, src_type'(s), 0));
            repeat (40) @(posedge CLK);
            chk(seg, sg[r]);
            fire(s);
            r = r ^ 1;
            until_seg(sg[r]);
            chk(seg, sg[r]);
            chk(link, lk[r]);
        end
        wb(1, 8'h00, 0);
        $display("test stepped done");
        row(1, 1);
        wb(1, 8'h08, 2);
        wb(1, 8'h00, ctl(MODE_AUTO, SRC_BUTTON, 0));
        until_seg(sg[1]);
        repeat (80) @(posedge CLK);
        chk(seg, sg[1]);
        fire(0);
        until_seg(sg[2]);
        chk(seg, sg[2]);
        wb(1, 8'h00, 0);
        $display("test jump done");
        results();
    end
endmodule
